// ===== rtl/slbic_defines.vh
`ifndef SLBIC_DEFINES_VH
`define SLBIC_DEFINES_VH

// register byte offsets
`define SLBIC_OFF_RX_STATUS   12'h000
`define SLBIC_OFF_RX_BUF      12'h004
`define SLBIC_OFF_TX_STATUS   12'h008
`define SLBIC_OFF_TX_BUF      12'h00c
`define SLBIC_OFF_CONFIG      12'h010

// receiver_status_reg fields
`define SLBIC_RS_MODEM_CHG    15
`define SLBIC_RS_RING         14
`define SLBIC_RS_CTS          13
`define SLBIC_RS_CARRIER      12
`define SLBIC_RS_SEC_RX       10
`define SLBIC_RS_DONE         7
`define SLBIC_RS_RX_IE        6
`define SLBIC_RS_MODEM_IE     5

// transmitter_status_reg fields
`define SLBIC_TS_READY        7
`define SLBIC_TS_TX_IE        6

// configuration register fields
`define SLBIC_CFG_W           10
`define SLBIC_CFG_VEC_HI      5
`define SLBIC_CFG_VEC_LO      0
`define SLBIC_CFG_LVL_HI      7
`define SLBIC_CFG_LVL_LO      6
`define SLBIC_CFG_MDIS        8
`define SLBIC_CFG_NPR         9
`define SLBIC_CFG_RST         10'h206

// buffer data width
`define SLBIC_DATA_W          16

// timing
`define SLBIC_CLK_NS          20
`define SLBIC_SSYN_NS         400
`define SLBIC_STROBE_NS       600

`endif

// ===== rtl/slbic_ctl.v
// Summary of operation
// - byte write to the high byte produces no register select or pulse
// - transmit buffer has no read path; reads return zero
// - transmit buffer write fires a load strobe latching the data
// - pready is held off while the load strobe is active
// - any read or low-byte write of receive buffer pulses the char-ready reset
// - receiver and transmitter request channels; receiver wins ties
// - vector base upper two octal digits set by six config bits
// - vector bit 2 low for receiver, high for transmitter
// - vector bits 1 and 0 are always driven as zero
// - rx enable bit 6 with char ready makes receiver request
// - modem enable bit 5 with modem change requests receiver channel
// - modem change flag set directly by modem input activity
// - option disables the modem interrupt source entirely
// - tx enable bit 6 with holding empty makes transmitter request
// - active request raises bus request on configured level, BR4 default
// - on grant answer sack, then take bbsy when bus is idle
// - hold mastership until the vector is strobed, then release
// - with no pending request pass grant down the chain
// - after service no new request until condition drops and returns
// - never requests npr; optionally waits while npr is pending
// - reading receiver status or reset clears the modem change flag
// - ring sets flag on rising edge, others on either edge
// - pready answers about 400 ns after the setup cycle
`include "slbic_defines.vh"

module slbic_ctl (
   input  wire        pclk,                 // bus clock
   input  wire        presetn,              // async reset, active low
   input  wire        psel,                 // apb select
   input  wire        penable,              // apb access phase
   input  wire        pwrite,               // apb direction
   input  wire [11:0] paddr,                // apb byte address
   input  wire [31:0] pwdata,               // apb write data
   input  wire [3:0]  pstrb,                // apb byte strobes
   output reg  [31:0] prdata,               // apb read data
   output reg         pready,               // apb ready
   output reg         pslverr,              // unmapped address
   input  wire [15:0] rx_data,              // received character
   input  wire        rx_char_ready,        // receiver done
   input  wire        tx_holding_empty,     // transmitter ready
   input  wire        ring_in,              // modem ring
   input  wire        carrier_in,           // modem carrier
   input  wire        clear_to_send_in,     // modem clear to send
   input  wire        secondary_receive_in, // modem secondary rx
   output reg  [15:0] tx_data,              // latched transmit data
   output reg         tx_load_strobe,       // transmit load pulse
   output reg         rx_done_reset,        // clears char ready
   input  wire        bg_in,                // bus grant in
   input  wire        bbsy_in,              // bus busy seen
   input  wire        ssyn_in,              // slave sync seen
   input  wire        npr_in,               // npr pending seen
   output reg  [3:0]  bus_request,          // request levels 4..7
   output reg         bg_out,               // bus grant out
   output reg         sack,                 // selection acknowledge
   output reg         bbsy_out,             // bus busy driven
   output reg         intr_out,             // interrupt strobe
   output reg  [8:0]  vec_out,              // vector value
   output reg         vec_oe                // vector drive enable
);

   localparam CNT_W = 6;

   function [CNT_W-1:0] ns_cycles;
      input integer ns;
      integer t;
      begin
         t = (ns + `SLBIC_CLK_NS - 1) / `SLBIC_CLK_NS;
         ns_cycles = t[CNT_W-1:0];
      end
   endfunction

   localparam [CNT_W-1:0] SSYN_CYC   = ns_cycles(`SLBIC_SSYN_NS);
   localparam [CNT_W-1:0] STROBE_CYC = ns_cycles(`SLBIC_STROBE_NS);
   localparam [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
   localparam [CNT_W-1:0] CNT_ZERO   = {CNT_W{1'b0}};

   localparam [1:0] ST_IDLE   = 2'h0;
   localparam [1:0] ST_REQ    = 2'h1;
   localparam [1:0] ST_ACK    = 2'h2;
   localparam [1:0] ST_MASTER = 2'h3;

   reg [CNT_W-1:0]       wait_cnt;
   reg [CNT_W-1:0]       strobe_cnt;
   reg                   rx_irq_enable;
   reg                   modem_irq_enable;
   reg                   tx_irq_enable;
   reg [`SLBIC_CFG_W-1:0] cfg;
   reg                   modem_change;
   reg                   ring_q;
   reg                   carrier_q;
   reg                   cts_q;
   reg                   sec_q;
   reg                   inh_rx;
   reg                   inh_tx;
   reg                   chan_tx;
   reg [1:0]             state;
   reg [31:0]            rd_val;

   wire sel_rs = paddr == `SLBIC_OFF_RX_STATUS;
   wire sel_rb = paddr == `SLBIC_OFF_RX_BUF;
   wire sel_ts = paddr == `SLBIC_OFF_TX_STATUS;
   wire sel_tb = paddr == `SLBIC_OFF_TX_BUF;
   wire sel_cf = paddr == `SLBIC_OFF_CONFIG;
   wire mapped = sel_rs | sel_rb | sel_ts | sel_tb | sel_cf;

   wire setup   = psel & ~penable;
   wire low_ok  = ~pwrite | pstrb[0];
   wire rd_take = psel & penable & ~pready &
                  (wait_cnt == CNT_ZERO) &
                  (strobe_cnt == CNT_ZERO);
   wire wr_done = psel & penable & pready & pwrite & pstrb[0];

   wire modem_evt = (ring_in & ~ring_q) |
                    (carrier_in ^ carrier_q) |
                    (clear_to_send_in ^ cts_q) |
                    (secondary_receive_in ^ sec_q);
   wire rs_read = rd_take & ~pwrite & sel_rs;

   wire rx_raw = (rx_irq_enable & rx_char_ready) |
                 (modem_irq_enable & modem_change &
                  ~cfg[`SLBIC_CFG_MDIS]);
   wire tx_raw   = tx_irq_enable & tx_holding_empty;
   wire rx_req   = rx_raw & ~inh_rx;
   wire tx_req   = tx_raw & ~inh_tx;
   wire npr_hold = cfg[`SLBIC_CFG_NPR] & npr_in;
   wire vec_done = (state == ST_MASTER) & ssyn_in;

   always @* begin
      rd_val = 32'h0000_0000;
      if (sel_rs) begin
         rd_val[`SLBIC_RS_MODEM_CHG] = modem_change;
         rd_val[`SLBIC_RS_RING]      = ring_in;
         rd_val[`SLBIC_RS_CTS]       = clear_to_send_in;
         rd_val[`SLBIC_RS_CARRIER]   = carrier_in;
         rd_val[`SLBIC_RS_SEC_RX]    = secondary_receive_in;
         rd_val[`SLBIC_RS_DONE]      = rx_char_ready;
         rd_val[`SLBIC_RS_RX_IE]     = rx_irq_enable;
         rd_val[`SLBIC_RS_MODEM_IE]  = modem_irq_enable;
      end else if (sel_rb) begin
         rd_val[`SLBIC_DATA_W-1:0] = rx_data;
      end else if (sel_ts) begin
         rd_val[`SLBIC_TS_READY] = tx_holding_empty;
         rd_val[`SLBIC_TS_TX_IE] = tx_irq_enable;
      end else if (sel_cf) begin
         rd_val[`SLBIC_CFG_W-1:0] = cfg;
      end
      // transmit buffer falls through as zero
   end

   // bus slave timing and side-effect pulses
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt       <= CNT_ZERO;
         strobe_cnt     <= CNT_ZERO;
         tx_load_strobe <= 1'b0;
         tx_data        <= 16'h0000;
         rx_done_reset  <= 1'b0;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         prdata         <= 32'h0000_0000;
      end else begin
         rx_done_reset <= setup & sel_rb & low_ok;
         if (setup & pwrite & pstrb[0] & sel_tb) begin
            strobe_cnt     <= STROBE_CYC;
            tx_load_strobe <= 1'b1;
            tx_data        <= pwdata[`SLBIC_DATA_W-1:0];
         end else if (strobe_cnt != CNT_ZERO) begin
            strobe_cnt     <= strobe_cnt - CNT_ONE;
            tx_load_strobe <= strobe_cnt != CNT_ONE;
         end
         if (setup) begin
            wait_cnt <= SSYN_CYC;
         end else if (wait_cnt != CNT_ZERO) begin
            wait_cnt <= wait_cnt - CNT_ONE;
         end
         pready <= rd_take;
         if (rd_take) begin
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
         end
      end
   end

   // software-visible control bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_irq_enable    <= 1'b0;
         modem_irq_enable <= 1'b0;
         tx_irq_enable    <= 1'b0;
         cfg              <= `SLBIC_CFG_RST;
      end else if (wr_done) begin
         if (sel_rs) begin
            rx_irq_enable    <= pwdata[`SLBIC_RS_RX_IE];
            modem_irq_enable <= pwdata[`SLBIC_RS_MODEM_IE];
         end
         if (sel_ts) begin
            tx_irq_enable <= pwdata[`SLBIC_TS_TX_IE];
         end
         if (sel_cf) begin
            cfg <= pwdata[`SLBIC_CFG_W-1:0];
         end
      end
   end

   // modem change flag; a new event wins over the read clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_change <= 1'b0;
         ring_q       <= 1'b0;
         carrier_q    <= 1'b0;
         cts_q        <= 1'b0;
         sec_q        <= 1'b0;
      end else begin
         ring_q       <= ring_in;
         carrier_q    <= carrier_in;
         cts_q        <= clear_to_send_in;
         sec_q        <= secondary_receive_in;
         modem_change <= modem_evt |
                         (modem_change & ~rs_read);
      end
   end

   // post-service inhibit until the condition drops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inh_rx <= 1'b0;
         inh_tx <= 1'b0;
      end else begin
         inh_rx <= rx_raw & (inh_rx | (vec_done & ~chan_tx));
         inh_tx <= tx_raw & (inh_tx | (vec_done & chan_tx));
      end
   end

   // bus request, grant and mastership sequence
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_IDLE;
         chan_tx     <= 1'b0;
         bus_request <= 4'h0;
         bg_out      <= 1'b0;
         sack        <= 1'b0;
         bbsy_out    <= 1'b0;
         intr_out    <= 1'b0;
         vec_out     <= 9'h000;
         vec_oe      <= 1'b0;
      end else begin
         bg_out <= bg_in & (state == ST_IDLE) &
                   ~(rx_req | tx_req);
         case (state)
            ST_IDLE: begin
               if ((rx_req | tx_req) & ~npr_hold) begin
                  bus_request <= 4'h1 <<
                     cfg[`SLBIC_CFG_LVL_HI:`SLBIC_CFG_LVL_LO];
                  state <= ST_REQ;
               end
            end
            ST_REQ: begin
               chan_tx <= ~rx_req;
               if (~rx_req & ~tx_req) begin
                  bus_request <= 4'h0;
                  state       <= ST_IDLE;
               end else if (bg_in) begin
                  bus_request <= 4'h0;
                  sack        <= 1'b1;
                  state       <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (~bbsy_in & ~ssyn_in & ~bg_in) begin
                  sack     <= 1'b0;
                  bbsy_out <= 1'b1;
                  intr_out <= 1'b1;
                  vec_out  <= {cfg[`SLBIC_CFG_VEC_HI:`SLBIC_CFG_VEC_LO],
                               chan_tx, 2'b00};
                  vec_oe   <= 1'b1;
                  state    <= ST_MASTER;
               end
            end
            ST_MASTER: begin
               if (ssyn_in) begin
                  bbsy_out <= 1'b0;
                  intr_out <= 1'b0;
                  vec_out  <= 9'h000;
                  vec_oe   <= 1'b0;
                  state    <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// ===== test/slbic_ctl_sva.sv
module slbic_ctl_sva (
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [3:0]  pstrb, bus_request,
   input wire logic [31:0] prdata,
   input wire logic        pready, tx_load_strobe, rx_done_reset, bg_in,
   input wire logic        bbsy_in, ssyn_in, bg_out, sack, bbsy_out,
   input wire logic        intr_out, vec_oe,
   input wire logic [8:0]  vec_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_tb_load;
      s_setup ##0 (pwrite && pstrb[0] && paddr == 12'h00c);
   endsequence
   sequence s_other;
      s_setup ##0 !(pwrite && pstrb[0] && paddr == 12'h00c);
   endsequence
   a_tx_load: assert property (s_tb_load |=> tx_load_strobe [*8])
      else $error("transmit load strobe missing");
   a_load_ready: assert property (tx_load_strobe |-> !pready)
      else $error("ready during load strobe");
   a_tb_answer: assert property (s_tb_load |-> ##[31:33] pready)
      else $error("transmit write answer late");
   a_ready_lat: assert property (s_other |-> ##[20:23] pready)
      else $error("answer latency wrong");
   a_rb_reset: assert property (s_setup ##0 (paddr == 12'h004
      && (!pwrite || pstrb[0])) |=> rx_done_reset ##1 !rx_done_reset)
      else $error("receive done reset pulse wrong");
   a_hi_byte: assert property (s_setup ##0 (pwrite && !pstrb[0])
      |=> !rx_done_reset && !tx_load_strobe)
      else $error("high byte write made a pulse");
   a_tb_noread: assert property (pready && !pwrite
      && paddr == 12'h00c |-> prdata == 32'h0000_0000)
      else $error("transmit buffer readable");
   a_grant_ack: assert property (|bus_request && bg_in
      |=> sack && bus_request == 4'h0)
      else $error("grant not acknowledged");
   a_bbsy_take: assert property ($rose(bbsy_out) |-> $past(sack)
      && !$past(bg_in) && !$past(bbsy_in) && !$past(ssyn_in))
      else $error("bus taken while not idle");
   a_release: assert property (bbsy_out && ssyn_in
      |=> !bbsy_out && !intr_out && !vec_oe)
      else $error("bus not released");
   a_vec_low: assert property (vec_oe |-> vec_out[1:0] == 2'b00)
      else $error("vector low bits set");
   a_no_pass: assert property (|bus_request || sack |=> !bg_out)
      else $error("grant passed while requesting");
   a_one_lvl: assert property ($onehot0(bus_request))
      else $error("more than one request level");
endmodule

bind slbic_ctl slbic_ctl_sva slbic_ctl_sva_inst (.*);

// ===== test/slbic_host_model.sv
module slbic_host_model (
   input  wire logic       pclk,        // bus clock
   input  wire logic [3:0] bus_request, // device request levels
   input  wire logic       sack,        // device acknowledge
   input  wire logic       intr_out,    // device interrupt strobe
   input  wire logic [8:0] vec_out,     // device vector
   output logic            bg_in,       // grant to device
   output logic            bbsy_in,     // bus busy by others
   output logic            ssyn_in,     // vector strobed in
   output logic            vec_stb,     // vector taken pulse
   output logic [8:0]      vec_seen     // vector taken
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {bg_in, bbsy_in, ssyn_in, vec_stb, vec_seen} = '0;
      forever begin
         @(posedge pclk);
         if (|bus_request) begin
            bbsy_in <= 1'b1;
            repeat ($urandom_range(3)) @(posedge pclk);
            bg_in <= 1'b1;
            while (!sack) @(posedge pclk);
            bg_in <= 1'b0;
            repeat ($urandom_range(2)) @(posedge pclk);
            bbsy_in <= 1'b0;
            while (!intr_out) @(posedge pclk);
            repeat ($urandom_range(3)) @(posedge pclk);
            vec_seen <= vec_out;
            vec_stb <= 1'b1;
            ssyn_in <= 1'b1;
            @(posedge pclk);
            vec_stb <= 1'b0;
            while (intr_out) @(posedge pclk);
            ssyn_in <= 1'b0;
         end
      end
   end
endmodule

// ===== test/slbic_ctl_tb_top.sv
module slbic_ctl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [3:0]  pstrb, bus_request;
   logic [15:0] rx_data, tx_data;
   logic        rx_char_ready, tx_holding_empty, ring_in, carrier_in;
   logic        clear_to_send_in, secondary_receive_in, tx_load_strobe;
   logic        rx_done_reset, bg_in, bbsy_in, ssyn_in, npr_in, bg_out;
   logic        sack, bbsy_out, intr_out, vec_oe, vec_stb, e;
   logic [8:0]  vec_out, vec_seen;
   logic [9:0]  cfg;
   logic [32:0] rq[$];
   logic [8:0]  vq[$];
   int          n_errors, checked, cyc;
   slbic_ctl slbic_ctl_inst (.*);
   slbic_host_model slbic_host_model_inst (.*);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (rq.size() != 0 || vq.size() != 0) n_errors++;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk);
      while (!pready);
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      rq.push_back({1'b0, x});
      apb(1'b0, a, 32'h0000_0000, 4'hf);
   endtask
   task automatic wait_vq;
      repeat (300) if (vq.size() != 0) @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (rx_done_reset) rx_char_ready <= 1'b0;
      if (psel && penable && pready && !pwrite)
         chk({pslverr, prdata}, rq.size() ? rq.pop_front() : 'x);
      if (vec_stb) chk(vec_seen, vq.size() ? vq.pop_front() : 'x);
      if (cyc == 6000) begin
         n_errors++;
         close_out();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, npr_in, rx_char_ready} = '0;
      {tx_holding_empty, ring_in, carrier_in, clear_to_send_in} = '0;
      {secondary_receive_in, paddr, pwdata, pstrb, rx_data, cyc} = '0;
      void'($urandom(32'h7df88cb8));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h010, 32'h0000_0206);
      rd(12'h000, 32'h0000_0000);
      rd(12'h00c, 32'h0000_0000);
      apb(1'b1, 12'h014, 32'h0000_0000, 4'h1);
      chk(e, 1'b1);
      d = $urandom;
      apb(1'b1, 12'h00c, d, 4'h1);
      chk(tx_data, d[15:0]);
      apb(1'b1, 12'h00c, ~d, 4'h2);
      chk(tx_data, d[15:0]);
      apb(1'b1, 12'h000, 32'h0000_0040, 4'h2);
      rd(12'h000, 32'h0000_0000);
      rx_data <= 16'($urandom);
      rx_char_ready <= 1'b1;
      vq.push_back(9'h030);
      apb(1'b1, 12'h000, 32'h0000_0040, 4'h1);
      wait_vq;
      repeat (40) @(posedge pclk);
      chk(bus_request, 4'h0);
      rd(12'h004, {16'h0000, rx_data});
      rx_char_ready <= 1'b1;
      vq.push_back(9'h030);
      wait_vq;
      rx_char_ready <= 1'b0;
      cfg = {2'b10, 2'($urandom), 6'($urandom)};
      apb(1'b1, 12'h010, {22'h0, cfg}, 4'h1);
      npr_in <= 1'b1;
      tx_holding_empty <= 1'b1;
      rx_char_ready <= 1'b1;
      apb(1'b1, 12'h008, 32'h0000_0040, 4'h1);
      apb(1'b1, 12'h000, 32'h0000_0040, 4'h1);
      chk(bus_request, 4'h0);
      vq.push_back({cfg[5:0], 3'b000});
      vq.push_back({cfg[5:0], 3'b100});
      npr_in <= 1'b0;
      repeat (10) if (bus_request == 4'h0) @(posedge pclk);
      chk(bus_request, 4'h1 << cfg[7:6]);
      wait_vq;
      rx_char_ready <= 1'b0;
      apb(1'b1, 12'h008, 32'h0000_0000, 4'h1);
      apb(1'b1, 12'h010, 32'h0000_0006, 4'h1);
      apb(1'b1, 12'h000, 32'h0000_0020, 4'h1);
      vq.push_back(9'h030);
      carrier_in <= 1'b1;
      wait_vq;
      rd(12'h000, 32'h0000_9020);
      rd(12'h000, 32'h0000_1020);
      vq.push_back(9'h030);
      ring_in <= 1'b1;
      wait_vq;
      rd(12'h000, 32'h0000_d020);
      ring_in <= 1'b0;
      rd(12'h000, 32'h0000_1020);
      apb(1'b1, 12'h010, 32'h0000_0106, 4'h1);
      clear_to_send_in <= 1'b1;
      repeat (30) @(posedge pclk);
      chk(bus_request, 4'h0);
      close_out();
   end
endmodule
